// *** pkg/bram_defines.svh ***
`ifndef BRAM_DEFINES_SVH
`define BRAM_DEFINES_SVH
// port shape codes, depth x width
`define W_1 3'h0
`define W_2 3'h1
`define W_4 3'h2
`define W_9 3'h3
`define W_18 3'h4
`define W_36 3'h5
`define W_72 3'h6
// output behaviour during a write
`define WM_RDF 2'h0
`define WM_WRF 2'h1
`define WM_NOCH 2'h2
// word pointer masks, full and half array
`define MSK_FULL 10'h3FF
`define MSK_HALF 10'h1FF
// queue capacity in 18-bit units
`define CAP_FULL 12'h800
`define CAP_HALF 12'h400
`define CNT_RST 12'h000
`endif

// *** pkg/bram_pkg.sv ***
package bram_pkg;
  typedef logic [2:0] wid_t;
  typedef logic [1:0] wmode_t;
  typedef struct packed {
    logic             slp;
    logic [1:0]       en;
    logic [1:0]       we;
    logic [1:0][14:0] addr;
    logic [1:0][71:0] din;
    logic [1:0][71:0] d1;
    logic [1:0][71:0] d2;
    logic             sbit;
    logic             dbit;
    logic [9:0]       wp;
    logic [10:0]      rp;
    logic [11:0]      cnt;
    logic [7:0]       echk;
    logic [63:0]      edat;
    logic             es;
    logic             ed;
  } state_t;
endpackage

// *** hdl/dual_port_block_memory_fifo.sv ***
`timescale 1ns/1ps
`include "bram_defines.svh"
// Behaviour
// - 36Kb array behind two independent ports
// - one 36Kb or two 18Kb arrays
// - every access happens on clock edge
// - cascade path to neighbour instance
// - data, address, enable, write registered
// - address held until next operation
// - optional output register adds one cycle
// - write output: old, new or unchanged
// - power gating input; unused stays asleep
// - 36Kb shapes 32Kx1 through 512x72
// - ports take different shapes, except A in split-role and queue
// - 18Kb halves 16Kx1 to 512x36
// - wide words only in split-role mode
// - split-role fixed side is 64/72 bits
// - dual-port 36Kb: both widths variable
// - 64-bit ECC: correct single, flag double
// - encoder and decoder usable standalone
// - queue mode of 36Kb or 18Kb
// - queue moves pointers, gives four flags
// - threshold flags follow user levels
// - queue read width may differ
// - queue chains through cascade path
module dual_port_block_memory_fifo
  import bram_pkg::*;
#(
  parameter bit USED  = 1'b1,
  parameter int THR_W = 12
) (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_sleep,
  input  wire logic        i_split,
  input  wire logic        i_split_role,
  input  wire logic        i_fifo_mode,
  input  wire logic        i_ecc_en,
  input  wire logic        i_addr_latch_off,
  input  wire logic [2:0]  i_wid_a,
  input  wire logic [2:0]  i_wid_b,
  input  wire logic [1:0]  i_wmode_a,
  input  wire logic [1:0]  i_wmode_b,
  input  wire logic        i_oreg_a,
  input  wire logic        i_oreg_b,
  input  wire logic        i_en_a,
  input  wire logic        i_we_a,
  input  wire logic [14:0] i_addr_a,
  input  wire logic [71:0] i_din_a,
  input  wire logic        i_en_b,
  input  wire logic        i_we_b,
  input  wire logic [14:0] i_addr_b,
  input  wire logic [71:0] i_din_b,
  input  wire logic        i_casc_sel,
  input  wire logic [71:0] i_casc_din,
  input  wire logic [11:0] i_pfull_thr,
  input  wire logic [11:0] i_pempty_thr,
  input  wire logic [63:0] i_ecc_enc_data,
  input  wire logic [71:0] i_ecc_dec_word,
  output logic      [71:0] o_dout_a,
  output logic      [71:0] o_dout_b,
  output logic      [71:0] o_casc_dout,
  output logic             o_sbit_err,
  output logic             o_dbit_err,
  output logic             o_full,
  output logic             o_empty,
  output logic             o_pfull,
  output logic             o_pempty,
  output logic      [7:0]  o_ecc_enc_chk,
  output logic      [63:0] o_ecc_dec_data,
  output logic             o_ecc_dec_sbit,
  output logic             o_ecc_dec_dbit
);

  if (THR_W != 12) begin : g_chk
    $error("threshold width must be 12");
  end

  // check bits: hamming positions 1..71 plus overall parity
  function automatic logic [7:0] ecc_enc(input logic [63:0] d);
    logic [71:0] cw;
    logic [7:0]  c;
    int          j;
    cw = '0;
    c  = '0;
    j  = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[j];
        j++;
      end
    end
    for (int i = 0; i < 7; i++) begin
      for (int p = 1; p < 72; p++) begin
        if (p[i]) c[i] = c[i] ^ cw[p];
      end
    end
    c[7] = (^d) ^ (^c[6:0]);
    return c;
  endfunction

  // returns {double, single, corrected data}
  function automatic logic [65:0] ecc_dec(input logic [71:0] w);
    logic [71:0] cw;
    logic [6:0]  syn;
    logic        ovr;
    logic        sb;
    logic        db;
    logic [63:0] d;
    int          j;
    cw  = '0;
    syn = '0;
    j   = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = w[j];
        j++;
      end
    end
    for (int i = 0; i < 7; i++) cw[1 << i] = w[64 + i];
    for (int i = 0; i < 7; i++) begin
      for (int p = 1; p < 72; p++) begin
        if (p[i]) syn[i] = syn[i] ^ cw[p];
      end
    end
    ovr = ^w;
    sb  = ovr;
    db  = (syn != 7'h00) && !ovr;
    if ((syn != 7'h00) && ovr) cw[syn] = !cw[syn];
    j = 0;
    d = '0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = cw[p];
        j++;
      end
    end
    return {db, sb, d};
  endfunction

  // shape helpers: word index, bit position, bit count
  function automatic wid_t wclamp(input wid_t w);
    return (w > `W_36) ? `W_36 : w;
  endfunction

  function automatic logic [9:0] widx(input wid_t w, input logic [14:0] a,
                                      input logic sp, input logic pb);
    logic [14:0] s;
    s = a >> (`W_36 - wclamp(w));
    return sp ? {pb, s[8:0]} : s[9:0];
  endfunction

  function automatic int bwid(input wid_t w);
    return (wclamp(w) >= `W_9) ? (9 << (wclamp(w) - 3)) : (1 << w);
  endfunction

  function automatic int bpos(input wid_t w, input logic [14:0] a);
    int wc;
    int n;
    wc = int'(wclamp(w));
    n  = int'(a) & ((1 << (5 - wc)) - 1);
    if (wc >= 3) return n * (9 << (wc - 3));
    return 9 * (n >> (3 - wc)) + ((n & ((8 >> wc) - 1)) << wc);
  endfunction

  function automatic logic [71:0] slice(input logic [35:0] v,
                                        input wid_t w, input logic [14:0] a);
    logic [35:0] m;
    m = (36'h1 << bwid(w)) - 36'h1;
    return {36'h0, (v >> bpos(w, a)) & m};
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] v,
                                        input logic [35:0] d,
                                        input wid_t w, input logic [14:0] a);
    logic [35:0] m;
    m = (36'h1 << bwid(w)) - 36'h1;
    return (v & ~(m << bpos(w, a))) | ((d & m) << bpos(w, a));
  endfunction

  state_t           st;
  state_t           s_next;
  logic [35:0]      mem [1024];
  logic [1:0]       wr_en;
  logic [1:0][9:0]  wr_idx;
  logic [1:0][35:0] wr_val;
  logic [9:0]       msk;
  logic [11:0]      cap;
  logic [11:0]      step;
  logic             wr_ok;
  logic             rd_ok;

  // queue flags from the registered fill count, in 18-bit units
  assign msk      = i_split ? `MSK_HALF : `MSK_FULL;
  assign cap      = i_split ? `CAP_HALF : `CAP_FULL;
  assign step     = (i_wid_b == `W_18) ? 12'h001 : 12'h002;
  assign o_full   = (st.cnt + 12'h002) > cap;
  assign o_empty  = st.cnt < step;
  assign o_pfull  = st.cnt >= i_pfull_thr;
  assign o_pempty = st.cnt <= i_pempty_thr;

  // next state: input capture, array access, queue control
  always_comb begin
    logic [35:0] old;
    logic [35:0] nw;
    logic [71:0] v72;
    logic [65:0] dec;
    logic [9:0]  ix;
    wid_t        w;
    wmode_t      wm;
    old    = '0;
    nw     = '0;
    v72    = '0;
    dec    = '0;
    ix     = '0;
    w      = '0;
    wm     = '0;
    s_next = st;
    wr_en  = '0;
    wr_idx = '0;
    wr_val = '0;
    wr_ok  = 1'b0;
    rd_ok  = 1'b0;
    s_next.slp = i_sleep | !USED;
    s_next.en  = {i_en_b, i_en_a};
    s_next.we  = {i_we_b, i_we_a};
    s_next.din = {i_din_b, i_din_a};
    if (i_en_a || i_addr_latch_off) s_next.addr[0] = i_addr_a;
    if (i_en_b || i_addr_latch_off) s_next.addr[1] = i_addr_b;
    s_next.d2 = st.d1;
    s_next.echk = ecc_enc(i_ecc_enc_data);
    {s_next.ed, s_next.es, s_next.edat} = ecc_dec(i_ecc_dec_word);
    // all accesses use the captured request
    if (!st.slp) begin
      if (i_fifo_mode) begin
        wr_ok = st.en[0] && !o_full;
        rd_ok = st.en[1] && !o_empty;
        if (wr_ok) begin
          wr_en[0]  = 1'b1;
          wr_idx[0] = st.wp;
          wr_val[0] = st.din[0][35:0];
          s_next.wp = (st.wp + 10'h001) & msk;
        end
        if (rd_ok) begin
          old = mem[st.rp[10:1]];
          if (step == 12'h001) begin
            s_next.d1[1] = {54'h0, st.rp[0] ? old[35:18] : old[17:0]};
          end else begin
            s_next.d1[1] = {36'h0, old};
          end
          s_next.rp = (st.rp + 11'(step)) & {msk, 1'b1};
        end
        s_next.cnt = st.cnt + (wr_ok ? 12'h002 : 12'h000)
                   - (rd_ok ? step : 12'h000);
      end else if (i_split_role) begin
        // write-only A, read-only B; A fixed 72
        v72 = i_ecc_en ? {ecc_enc(st.din[0][63:0]), st.din[0][63:0]}
                       : st.din[0];
        if (st.en[0] && st.we[0]) begin
          wr_en     = 2'h3;
          wr_idx[0] = {st.addr[0][8:0], 1'b0};
          wr_idx[1] = {st.addr[0][8:0], 1'b1};
          wr_val[0] = v72[35:0];
          wr_val[1] = v72[71:36];
        end
        if (st.en[1]) begin
          if (i_wid_b == `W_72) begin
            v72 = {mem[{st.addr[1][8:0], 1'b1}],
                   mem[{st.addr[1][8:0], 1'b0}]};
            dec = ecc_dec(v72);
            s_next.d1[1] = i_ecc_en ? {8'h00, dec[63:0]} : v72;
            s_next.sbit  = i_ecc_en & dec[64];
            s_next.dbit  = i_ecc_en & dec[65];
          end else begin
            ix = widx(i_wid_b, st.addr[1], 1'b0, 1'b0);
            s_next.d1[1] = slice(mem[ix], i_wid_b, st.addr[1]);
          end
        end
      end else begin
        for (int p = 0; p < 2; p++) begin
          w  = p[0] ? i_wid_b : i_wid_a;
          wm = p[0] ? i_wmode_b : i_wmode_a;
          // split gives each port its own half
          // address width covers 32K x 1
          ix  = widx(w, st.addr[p], i_split, p[0]);
          old = mem[ix];
          nw  = merge(old, st.din[p][35:0], w, st.addr[p]);
          if (st.en[p]) begin
            if (st.we[p]) begin
              wr_en[p]  = 1'b1;
              wr_idx[p] = ix;
              wr_val[p] = nw;
              if (wm == `WM_RDF) begin
                s_next.d1[p] = slice(old, w, st.addr[p]);
              end else if (wm == `WM_WRF) begin
                s_next.d1[p] = slice(nw, w, st.addr[p]);
              end
            end else begin
              s_next.d1[p] = slice(old, w, st.addr[p]);
            end
          end
        end
      end
      if (i_casc_sel) s_next.d1[1] = i_casc_din;
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st     <= '0;
      st.slp <= 1'b1;
      st.cnt <= `CNT_RST;
    end else begin
      st <= s_next;
    end
  end

  // array writes; on a same-word write port B wins
  always_ff @(posedge i_mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (wr_en[p]) mem[wr_idx[p]] <= wr_val[p];
    end
  end

  // outputs straight from flops
  assign o_dout_a       = i_oreg_a ? st.d2[0] : st.d1[0];
  assign o_dout_b       = i_oreg_b ? st.d2[1] : st.d1[1];
  assign o_casc_dout    = o_dout_b;
  assign o_sbit_err     = st.sbit;
  assign o_dbit_err     = st.dbit;
  assign o_ecc_enc_chk  = st.echk;
  assign o_ecc_dec_data = st.edat;
  assign o_ecc_dec_sbit = st.es;
  assign o_ecc_dec_dbit = st.ed;

  chk_input_capture: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_en_a |=> st.addr[0] == $past(i_addr_a) && st.en[0])
    else $error("port address not captured");

  chk_addr_hold: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    !i_en_a && !i_addr_latch_off |=> $stable(st.addr[0]))
    else $error("address changed without operation");

  chk_pipe_extra: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_oreg_a && $past(i_oreg_a) |-> o_dout_a == $past(st.d1[0]))
    else $error("output stage not one cycle late");

  chk_nochange_hold: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    st.en[0] && st.we[0] && !st.slp && !i_fifo_mode && !i_split_role
    && i_wmode_a == `WM_NOCH |=> $stable(st.d1[0]))
    else $error("output moved on no-change write");

  chk_sleep_hold: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    st.slp |=> $stable(st.d1) && $stable(st.cnt))
    else $error("sleeping array changed");

  chk_full_block: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_fifo_mode && o_full |=> $stable(st.wp))
    else $error("write pointer moved while full");

  chk_empty_flag: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    st.cnt == 12'h000 |-> o_empty && !o_full)
    else $error("empty flag wrong at zero fill");

  chk_thresh_flags: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    o_pfull == (st.cnt >= i_pfull_thr)
    && o_pempty == (st.cnt <= i_pempty_thr))
    else $error("threshold flag mismatch");

  chk_ecc_roundtrip: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_ecc_dec_word == {ecc_enc(i_ecc_enc_data), i_ecc_enc_data}
    |=> !o_ecc_dec_sbit && !o_ecc_dec_dbit
    && o_ecc_dec_data == $past(i_ecc_enc_data)
    && o_ecc_enc_chk == $past(i_ecc_dec_word[71:64]))
    else $error("clean codeword not passed");

endmodule

// *** tb/fabric_user.sv ***
`timescale 1ns/1ps
module fabric_user (
  input  wire logic        i_mclk,
  input  wire logic        i_full,
  input  wire logic        i_empty,
  output logic [1:0]       o_en,
  output logic [1:0]       o_we,
  output logic [1:0][14:0] o_addr,
  output logic [1:0][71:0] o_din
);
  // requests idle low from time zero
  initial begin
    o_en = 2'h0;
    o_we = 2'h0;
    o_addr = 30'h0;
    o_din = 144'h0;
  end
  // one strobe on one port; lines scrambled once released
  // one port only
  task automatic acc(input int p, input logic w, input logic [14:0] a,
                     input logic [71:0] d);
    @(posedge i_mclk);
    o_en[p] <= 1'b1;
    o_we[p] <= w;
    o_addr[p] <= a;
    o_din[p] <= d;
    @(posedge i_mclk);
    o_en[p] <= 1'b0;
    o_we[p] <= 1'b0;
    o_addr[p] <= ~a;
    o_din[p] <= ~d;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic push(input logic [71:0] d, output bit ok);
    ok = !i_full;
    if (ok)
      acc(0, 1'b1, 15'h0, d);
  endtask
  task automatic pop(output bit ok);
    ok = !i_empty;
    if (ok)
      acc(1, 1'b0, 15'h0, 72'h0);
  endtask
endmodule

// *** tb/dual_port_block_memory_fifo_tb_top.sv ***
`timescale 1ns/1ps
`include "bram_defines.svh"
module dual_port_block_memory_fifo_tb_top;
  import bram_pkg::*;
  logic             i_mclk = 1'b0;
  logic             rst = 1'b1;
  logic             sleep = 1'b0;
  logic             split = 1'b0;
  logic             fmode = 1'b0;
  logic             oreg = 1'b0;
  logic             csel = 1'b0;
  logic             srole = 1'b0;
  logic             ecc = 1'b0;
  wid_t             wid_b = `W_36;
  logic             sbe;
  logic             dbe;
  wid_t             wid_a = `W_36;
  wmode_t           wm = `WM_RDF;
  logic [11:0]      pf_thr = 12'h000;
  logic [11:0]      pe_thr = 12'h000;
  logic [71:0]      cdin = 72'h0;
  logic [63:0]      enc_d = 64'h0;
  logic [71:0]      dec_w = 72'h0;
  logic [1:0]       en;
  logic [1:0]       we;
  logic [1:0][14:0] addr;
  logic [1:0][71:0] din;
  logic [71:0]      dout_a;
  logic [71:0]      dout_b;
  logic [71:0]      cdout;
  logic [7:0]       enc_c;
  logic [63:0]      dec_d;
  logic             full;
  logic             empty;
  logic             pfull;
  logic             pempty;
  logic             dsb;
  logic             ddb;
  logic [35:0]      mem [int];
  logic [35:0]      fq [$];
  int               n_errors = 0;
  int               total_checks = 0;
  int               cycles = 0;

  dual_port_block_memory_fifo #(.USED(1'b1), .THR_W(12))
    i_dual_port_block_memory_fifo (
    .i_mclk(i_mclk), .i_sys_rst(rst), .i_sleep(sleep), .i_split(split),
    .i_split_role(srole), .i_fifo_mode(fmode), .i_ecc_en(ecc),
    .i_addr_latch_off(1'b0), .i_wid_a(wid_a), .i_wid_b(wid_b),
    .i_wmode_a(wm), .i_wmode_b(wm), .i_oreg_a(oreg), .i_oreg_b(oreg),
    .i_en_a(en[0]), .i_we_a(we[0]), .i_addr_a(addr[0]), .i_din_a(din[0]),
    .i_en_b(en[1]), .i_we_b(we[1]), .i_addr_b(addr[1]), .i_din_b(din[1]),
    .i_casc_sel(csel), .i_casc_din(cdin), .i_pfull_thr(pf_thr),
    .i_pempty_thr(pe_thr), .i_ecc_enc_data(enc_d), .i_ecc_dec_word(dec_w),
    .o_dout_a(dout_a), .o_dout_b(dout_b), .o_casc_dout(cdout),
    .o_sbit_err(sbe), .o_dbit_err(dbe), .o_full(full), .o_empty(empty),
    .o_pfull(pfull), .o_pempty(pempty), .o_ecc_enc_chk(enc_c),
    .o_ecc_dec_data(dec_d), .o_ecc_dec_sbit(dsb), .o_ecc_dec_dbit(ddb));

  fabric_user i_fabric_user (
    .i_mclk(i_mclk), .i_full(full), .i_empty(empty),
    .o_en(en), .o_we(we), .o_addr(addr), .o_din(din));

  // free-running clock and hang guard
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [71:0] e,
                     input logic [71:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  function automatic logic [71:0] rnd72();
    return 72'({$urandom(), $urandom(), $urandom()});
  endfunction

  // model write, port B maps to upper half when split
  task automatic wr(input int p, input int w, input logic [71:0] d);
    i_fabric_user.acc(p, 1'b1, 15'(w), d);
    mem[(p == 1 && split) ? w + 512 : w] = d[35:0];
  endtask

  task automatic rd(input int p, input int w, input logic [35:0] e);
    i_fabric_user.acc(p, 1'b0, 15'(w), 72'h0);
    chk("dout", 72'(e), 72'(p == 1 ? dout_b[35:0] : dout_a[35:0]));
  endtask

  // queue flags against the model fill count in 18-bit units
  task automatic flags();
    int c;
    c = 2 * fq.size();
    chk("full", 72'(c == int'(`CAP_FULL)), 72'(full));
    chk("empty", 72'(c == 0), 72'(empty));
    chk("pfull", 72'(c >= int'(pf_thr)), 72'(pfull));
    chk("pempty", 72'(c <= int'(pe_thr)), 72'(pempty));
  endtask

  task automatic rst_pulse();
    @(posedge i_mclk);
    rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    rst <= 1'b0;
  endtask

  initial begin
    int w;
    int x;
    int k;
    bit ok;
    logic [35:0] e;
    logic [71:0] d;
    logic [63:0] m64;
    void'($urandom(32'h17A9E527));
    repeat (12) @(posedge i_mclk);
    #1;
    chk("rst_empty", 72'h1, 72'(empty));
    chk("rst_dout", 72'h0, dout_a);
    rst <= 1'b0;
    // shared array, alternate ports
    for (int i = 0; i < 8; i++) begin
      wr(i % 2, 37 * i + 5, rnd72());
      rd(1 - i % 2, 37 * i + 5, mem[37 * i + 5]);
    end
    k = $urandom_range(7);
    w = 37 * k + 5;
    x = 37 * ((k + 1) % 8) + 5;
    rd(1, x, mem[x]);
    @(posedge i_mclk);
    oreg <= 1'b1;
    i_fabric_user.acc(1, 1'b0, 15'(w), 72'h0);
    chk("oreg_early", 72'(mem[x]), 72'(dout_b[35:0]));
    @(posedge i_mclk);
    #1;
    chk("oreg_late", 72'(mem[w]), 72'(dout_b[35:0]));
    oreg <= 1'b0;
    // output during a write, per mode
    for (int m = 0; m < 3; m++) begin
      @(posedge i_mclk);
      wm <= 2'(m);
      rd(0, x, mem[x]);
      e = mem[w];
      d = rnd72();
      wr(0, w, d);
      e = m == 0 ? e : m == 1 ? d[35:0] : mem[x];
      chk("wmode", 72'(e), 72'(dout_a[35:0]));
    end
    // narrow lanes on A, whole word on B
    @(posedge i_mclk);
    wid_a <= `W_9;
    for (int l = 0; l < 4; l++) begin
      d = rnd72();
      i_fabric_user.acc(0, 1'b1, 15'(4 * w + l), d);
      mem[w][9 * l +: 9] = d[8:0];
    end
    @(posedge i_mclk);
    wid_a <= `W_36;
    rd(1, w, mem[w]);
    @(posedge i_mclk);
    sleep <= 1'b1;
    i_fabric_user.acc(0, 1'b1, 15'(w), rnd72());
    @(posedge i_mclk);
    sleep <= 1'b0;
    rd(1, w, mem[w]);
    @(posedge i_mclk);
    split <= 1'b1;
    wr(0, 5, rnd72());
    wr(1, 5, rnd72());
    rd(0, 5, mem[5]);
    rd(1, 5, mem[517]);
    @(posedge i_mclk);
    split <= 1'b0;
    csel <= 1'b1;
    cdin <= rnd72();
    i_fabric_user.acc(1, 1'b0, 15'(w), 72'h0);
    chk("casc_b", cdin, dout_b);
    chk("casc_out", cdin, cdout);
    csel <= 1'b0;
    // split-role: protected 72-bit write on A, wide and narrow reads on B
    @(posedge i_mclk);
    srole <= 1'b1;
    ecc <= 1'b1;
    wid_b <= `W_72;
    d = rnd72();
    i_fabric_user.acc(0, 1'b1, 15'h12C, d);
    i_fabric_user.acc(1, 1'b0, 15'h12C, 72'h0);
    chk("srole_72", {8'h00, d[63:0]}, dout_b);
    chk("srole_sbit", 72'h0, 72'(sbe));
    chk("srole_dbit", 72'h0, 72'(dbe));
    @(posedge i_mclk);
    wid_b <= `W_36;
    i_fabric_user.acc(1, 1'b0, 15'h258, 72'h0);
    chk("srole_36", 72'(d[35:0]), dout_b);
    @(posedge i_mclk);
    srole <= 1'b0;
    ecc <= 1'b0;
    // codec: clean, one flipped bit, two flipped bits
    for (int f = 0; f < 3; f++) begin
      @(posedge i_mclk);
      enc_d <= 64'({$urandom(), $urandom()});
      @(posedge i_mclk);
      #1;
      k = $urandom_range(62);
      m64 = f == 0 ? 64'h0 : f == 1 ? 64'h1 << k : 64'h3 << k;
      @(posedge i_mclk);
      dec_w <= {enc_c, enc_d ^ m64};
      @(posedge i_mclk);
      #1;
      if (f < 2)
        chk("dec_data", 72'(enc_d), 72'(dec_d));
      chk("dec_sbit", 72'(f == 1), 72'(dsb));
      chk("dec_dbit", 72'(f == 2), 72'(ddb));
    end
    // queue: fill past full, then drain
    fmode <= 1'b1;
    pf_thr <= 12'($urandom_range(2047));
    pe_thr <= 12'($urandom_range(2047));
    rst_pulse();
    for (int i = 0; i < 1025; i++) begin
      d = rnd72();
      i_fabric_user.push(d, ok);
      if (ok)
        fq.push_back(d[35:0]);
      flags();
    end
    i_fabric_user.acc(0, 1'b1, 15'h0, rnd72());
    flags();
    while (fq.size() > 0) begin
      i_fabric_user.pop(ok);
      if (ok)
        chk("pop", 72'(fq.pop_front()), 72'(dout_b[35:0]));
      flags();
    end
    tally_and_finish();
  end
endmodule
